// file: src/pot_pkg.sv
// Package: register map, reset values and field layout of the pattern output unit
package pot_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] POT_OFS_LOW_EN    = 8'h00;
  localparam logic [7:0] POT_OFS_HIGH_EN   = 8'h04;
  localparam logic [7:0] POT_OFS_TRIG_SEL  = 8'h08;
  localparam logic [7:0] POT_OFS_LOW_STG   = 8'h0C;
  localparam logic [7:0] POT_OFS_HIGH_STG  = 8'h10;
  localparam logic [7:0] POT_OFS_PORT_A    = 8'h14;
  localparam logic [7:0] POT_OFS_PORT_B    = 8'h18;
  localparam logic [7:0] POT_OFS_DIR_A     = 8'h1C;
  localparam logic [7:0] POT_OFS_DIR_B     = 8'h20;
  localparam logic [7:0] POT_OFS_STATUS    = 8'h24;

  // ****************************************
  // Values after reset
  // ****************************************
  localparam logic [7:0] POT_RST_LOW_EN    = 8'h00;
  localparam logic [7:0] POT_RST_HIGH_EN   = 8'h00;
  localparam logic [7:0] POT_RST_TRIG_SEL  = 8'hFF;
  localparam logic [7:0] POT_RST_STAGED    = 8'h00;
  localparam logic [7:0] POT_RST_LATCH     = 8'h00;
  localparam logic [7:0] POT_RST_DIR       = 8'h00;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int POT_REG_W    = 8;
  localparam int POT_NUM_GRP  = 4;
  localparam int POT_GRP_PINS = 4;
  localparam int POT_SEL_W    = 2;
  localparam int POT_NUM_CH   = 3;

  // Trigger select codes; any code with the upper bit set picks channel 2
  localparam logic [1:0] POT_SEL_CH0 = 2'h0;
  localparam logic [1:0] POT_SEL_CH1 = 2'h1;

endpackage

// file: src/pot_group_trigger.sv
// Per-group selection of the compare match strobe that triggers a transfer
`timescale 1ns/1ps
module pot_group_trigger
  import pot_pkg::*;
#(
  parameter int NUM_GRP = POT_NUM_GRP
) (
  // Trigger selection
  input  wire logic [2*NUM_GRP-1:0] sel_i,
  // Timer strobes
  input  wire logic [2:0]           cmp_match_i,
  // Per-group strobe
  output logic      [NUM_GRP-1:0]   grp_strobe_o
);

  // ****************************************
  // Channel decode per group
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NUM_GRP; g++) begin : gen_grp
      wire logic [1:0] code = sel_i[2*g +: 2];
      // 00 = ch0, 01 = ch1, 1x = ch2
      assign grp_strobe_o[g] = (code == POT_SEL_CH0) ? cmp_match_i[0] :
                               (code == POT_SEL_CH1) ? cmp_match_i[1] :
                                                       cmp_match_i[2];
    end
  endgenerate

endmodule

// file: src/pot_pin_latch.sv
// Port output data latch with pattern transfer and write protection per bit
`timescale 1ns/1ps
module pot_pin_latch
  import pot_pkg::*;
#(
  parameter int W = POT_REG_W
) (
  // Clock and clear
  input  wire logic         core_clk_i,
  input  wire logic         clr_i,
  // Software write
  input  wire logic         sw_we_i,
  input  wire logic [W-1:0] sw_wdata_i,
  // Pattern transfer
  input  wire logic [W-1:0] enable_i,
  input  wire logic [W-1:0] xfer_i,
  input  wire logic [W-1:0] staged_i,
  // Latch contents
  output logic      [W-1:0] latch_o
);

  logic [W-1:0] latch_q;
  logic [W-1:0] latch_d;

  // ****************************************
  // Next value per bit
  // ****************************************
  genvar b;
  generate
    for (b = 0; b < W; b++) begin : gen_bit
      wire logic take_xfer = enable_i[b] & xfer_i[b];
      wire logic take_sw   = sw_we_i & ~enable_i[b];
      // Disabled bits ignore the strobe entirely
      assign latch_d[b] = take_xfer ? staged_i[b] :
                          take_sw   ? sw_wdata_i[b] :
                                      latch_q[b];
    end
  endgenerate

  always_ff @(posedge core_clk_i) begin
    if (clr_i) begin
      latch_q <= POT_RST_LATCH[W-1:0];
    end else begin
      latch_q <= latch_d;
    end
  end

  assign latch_o = latch_q;

endmodule

// file: src/pot_top.sv
// Pattern output unit: enable and trigger selection with APB register access
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
module pot_top
  import pot_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  // Hardware standby pin, asynchronous to the clock
  input  wire logic              hw_standby_i,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Timer compare match strobes, same clock
  input  wire logic [2:0]        cmp_match_i,
  // Pattern pins
  output logic      [15:0]       pattern_pins_o,
  output logic      [15:0]       pattern_pins_oe_o,
  output logic      [15:0]       pattern_active_o
);

  // ****************************************
  // Standby synchroniser
  // ****************************************
  logic stby_meta_q;
  logic stby_sync_q;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      stby_meta_q <= 1'b0;
      stby_sync_q <= 1'b0;
    end else begin
      stby_meta_q <= hw_standby_i;
      stby_sync_q <= stby_meta_q;
    end
  end

  // Standby clears like reset; software standby needs nothing here
  wire logic clr = rst_i | stby_sync_q;

  // ****************************************
  // APB decode
  // ****************************************
  wire logic       setup   = psel & ~penable;
  wire logic       access  = psel & penable;
  wire logic [7:0] ofs     = paddr[7:0];
  wire logic       hi_zero = (ADDR_W > 8) ? (paddr >> 8) == '0 : 1'b1;
  wire logic       lane0   = pstrb[0];

  wire logic hit_low_en   = hi_zero & (ofs == POT_OFS_LOW_EN);
  wire logic hit_high_en  = hi_zero & (ofs == POT_OFS_HIGH_EN);
  wire logic hit_trig     = hi_zero & (ofs == POT_OFS_TRIG_SEL);
  wire logic hit_low_stg  = hi_zero & (ofs == POT_OFS_LOW_STG);
  wire logic hit_high_stg = hi_zero & (ofs == POT_OFS_HIGH_STG);
  wire logic hit_port_a   = hi_zero & (ofs == POT_OFS_PORT_A);
  wire logic hit_port_b   = hi_zero & (ofs == POT_OFS_PORT_B);
  wire logic hit_dir_a    = hi_zero & (ofs == POT_OFS_DIR_A);
  wire logic hit_dir_b    = hi_zero & (ofs == POT_OFS_DIR_B);
  wire logic hit_status   = hi_zero & (ofs == POT_OFS_STATUS);

  wire logic mapped = hit_low_en | hit_high_en | hit_trig | hit_low_stg | hit_high_stg |
                      hit_port_a | hit_port_b | hit_dir_a | hit_dir_b | hit_status;

  // Writes land at the access edge, only through byte lane 0
  wire logic wr      = access & pwrite & lane0;
  wire logic we_low_en   = wr & hit_low_en;
  wire logic we_high_en  = wr & hit_high_en;
  wire logic we_trig     = wr & hit_trig;
  wire logic we_low_stg  = wr & hit_low_stg;
  wire logic we_high_stg = wr & hit_high_stg;
  wire logic we_port_a   = wr & hit_port_a;
  wire logic we_port_b   = wr & hit_port_b;
  wire logic we_dir_a    = wr & hit_dir_a;
  wire logic we_dir_b    = wr & hit_dir_b;

  wire logic [7:0] wbyte = pwdata[7:0];

  // ****************************************
  // Enable and trigger select registers
  // ****************************************
  logic [7:0] low_pin_output_enable_q;
  logic [7:0] high_pin_output_enable_q;
  logic [7:0] group_trigger_select_q;

  always_ff @(posedge core_clk_i) begin
    if (clr) begin
      low_pin_output_enable_q <= POT_RST_LOW_EN;
    end else if (we_low_en) begin
      low_pin_output_enable_q <= wbyte;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (clr) begin
      high_pin_output_enable_q <= POT_RST_HIGH_EN;
    end else if (we_high_en) begin
      high_pin_output_enable_q <= wbyte;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (clr) begin
      group_trigger_select_q <= POT_RST_TRIG_SEL;
    end else if (we_trig) begin
      group_trigger_select_q <= wbyte;
    end
  end

  // ****************************************
  // Staged pattern and direction registers
  // ****************************************
  logic [7:0] low_staged_pattern_q;
  logic [7:0] high_staged_pattern_q;
  logic [7:0] port_a_direction_q;
  logic [7:0] port_b_direction_q;

  always_ff @(posedge core_clk_i) begin
    if (clr) begin
      low_staged_pattern_q  <= POT_RST_STAGED;
      high_staged_pattern_q <= POT_RST_STAGED;
    end else begin
      if (we_low_stg) begin
        low_staged_pattern_q <= wbyte;
      end
      if (we_high_stg) begin
        high_staged_pattern_q <= wbyte;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (clr) begin
      port_a_direction_q <= POT_RST_DIR;
      port_b_direction_q <= POT_RST_DIR;
    end else begin
      if (we_dir_a) begin
        port_a_direction_q <= wbyte;
      end
      if (we_dir_b) begin
        port_b_direction_q <= wbyte;
      end
    end
  end

  // ****************************************
  // Trigger selection
  // ****************************************
  logic [POT_NUM_GRP-1:0] grp_strobe;

  pot_group_trigger #(
    .NUM_GRP (POT_NUM_GRP)
  ) u_trig (
    .sel_i        (group_trigger_select_q),
    .cmp_match_i  (cmp_match_i),
    .grp_strobe_o (grp_strobe)
  );

  // All four pins of a group share its strobe; the latch gates it per pin by enable
  wire logic [7:0] xfer_low  = {{4{grp_strobe[1]}}, {4{grp_strobe[0]}}};
  wire logic [7:0] xfer_high = {{4{grp_strobe[3]}}, {4{grp_strobe[2]}}};

  // ****************************************
  // Port output latches
  // ****************************************
  logic [7:0] port_a_output_latch;
  logic [7:0] port_b_output_latch;

  pot_pin_latch #(
    .W (POT_REG_W)
  ) u_port_a (
    .core_clk_i (core_clk_i),
    .clr_i      (clr),
    .sw_we_i    (we_port_a),
    .sw_wdata_i (wbyte),
    .enable_i   (low_pin_output_enable_q),
    .xfer_i     (xfer_low),
    .staged_i   (low_staged_pattern_q),
    .latch_o    (port_a_output_latch)
  );

  pot_pin_latch #(
    .W (POT_REG_W)
  ) u_port_b (
    .core_clk_i (core_clk_i),
    .clr_i      (clr),
    .sw_we_i    (we_port_b),
    .sw_wdata_i (wbyte),
    .enable_i   (high_pin_output_enable_q),
    .xfer_i     (xfer_high),
    .staged_i   (high_staged_pattern_q),
    .latch_o    (port_b_output_latch)
  );

  // ****************************************
  // Pattern mode flags
  // ****************************************
  // Built from next register values so the flag lands with the write
  // Costs a second set of write muxes, but the output stays a flop
  wire logic [7:0]  low_en_d   = we_low_en  ? wbyte : low_pin_output_enable_q;
  wire logic [7:0]  high_en_d  = we_high_en ? wbyte : high_pin_output_enable_q;
  wire logic [7:0]  dir_a_d    = we_dir_a   ? wbyte : port_a_direction_q;
  wire logic [7:0]  dir_b_d    = we_dir_b   ? wbyte : port_b_direction_q;
  wire logic [15:0] active_d   = {dir_b_d & high_en_d, dir_a_d & low_en_d};
  wire logic [15:0] active_rst = {POT_RST_DIR & POT_RST_HIGH_EN, POT_RST_DIR & POT_RST_LOW_EN};
  logic      [15:0] pattern_active_q;

  always_ff @(posedge core_clk_i) begin
    if (clr) begin
      pattern_active_q <= active_rst;
    end else begin
      pattern_active_q <= active_d;
    end
  end

  // ****************************************
  // Pin outputs
  // ****************************************
  wire logic [15:0] directions = {port_b_direction_q, port_a_direction_q};

  // Latch drives the pin at all times; a transfer only reloads the latch
  assign pattern_pins_o    = {port_b_output_latch, port_a_output_latch};
  assign pattern_pins_oe_o = directions;
  assign pattern_active_o  = pattern_active_q;

  // ****************************************
  // Read data
  // ****************************************
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    if (hit_low_en) begin
      rd_mux = low_pin_output_enable_q;
    end else if (hit_high_en) begin
      rd_mux = high_pin_output_enable_q;
    end else if (hit_trig) begin
      rd_mux = group_trigger_select_q;
    end else if (hit_low_stg) begin
      rd_mux = low_staged_pattern_q;
    end else if (hit_high_stg) begin
      rd_mux = high_staged_pattern_q;
    end else if (hit_port_a) begin
      rd_mux = port_a_output_latch;
    end else if (hit_port_b) begin
      rd_mux = port_b_output_latch;
    end else if (hit_dir_a) begin
      rd_mux = port_a_direction_q;
    end else if (hit_dir_b) begin
      rd_mux = port_b_direction_q;
    end
  end

  // Status is wider than a byte, so it bypasses the byte mux
  wire logic [31:0] rd_word = hit_status ? {16'h0000, pattern_active_o} : {24'h00_0000, rd_mux};

  // Captured in setup so the access phase answers at once from a flop
  logic [31:0] prdata_q;
  logic        err_q;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      prdata_q <= 32'h0000_0000;
      err_q    <= 1'b0;
    end else if (setup) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rd_word;
      err_q    <= ~mapped;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = access & err_q;

endmodule

// file: testbench/pot_top_monitor.sv
// Checker of the pattern output unit port behaviour
`timescale 1ns/1ps
module pot_top_monitor
  import pot_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic              core_clk_i,
  input wire logic              rst_i,
  input wire logic              hw_standby_i,
  // Register bus
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic              pslverr,
  // Strobes and pins
  input wire logic [2:0]        cmp_match_i,
  input wire logic [15:0]       pattern_pins_o,
  input wire logic [15:0]       pattern_pins_oe_o,
  input wire logic [15:0]       pattern_active_o
);
  // ******************************
  // Shadow of the trigger select
  // ******************************
  logic [7:0] sel_q;
  logic [3:0] hit;
  logic       acc;
  logic       wr_a;
  logic       wr_b;
  assign acc  = psel && penable && pwrite;
  assign wr_a = acc && paddr == ADDR_W'(POT_OFS_PORT_A);
  assign wr_b = acc && paddr == ADDR_W'(POT_OFS_PORT_B);
  for (genvar g = 0; g < 4; g++) begin : g_hit
    assign hit[g] = sel_q[2*g+1] ? cmp_match_i[2] : cmp_match_i[sel_q[2*g]];
  end
  // Standby clears at once here; the design lags, but checks are off then
  always_ff @(posedge core_clk_i) begin
    if (rst_i || hw_standby_i) begin
      sel_q <= POT_RST_TRIG_SEL;
    end else if (acc && pstrb[0] && paddr == ADDR_W'(POT_OFS_TRIG_SEL)) begin
      sel_q <= pwdata[7:0];
    end
  end
  // ******************************
  // Assertions
  // ******************************
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i || hw_standby_i);
  property p_grp0;
    $changed(pattern_pins_o[3:0]) |-> $past(hit[0]) || $past(wr_a);
  endproperty
  a_grp0: assert property (p_grp0) else $error("group 0 moved without its strobe");
  property p_grp1;
    $changed(pattern_pins_o[7:4]) |-> $past(hit[1]) || $past(wr_a);
  endproperty
  a_grp1: assert property (p_grp1) else $error("group 1 moved without its strobe");
  property p_grp2;
    $changed(pattern_pins_o[11:8]) |-> $past(hit[2]) || $past(wr_b);
  endproperty
  a_grp2: assert property (p_grp2) else $error("group 2 moved without its strobe");
  property p_grp3;
    $changed(pattern_pins_o[15:12]) |-> $past(hit[3]) || $past(wr_b);
  endproperty
  a_grp3: assert property (p_grp3) else $error("group 3 moved without its strobe");
  property p_ro;
    wr_a && !hit[0] && !hit[1] |=>
      ((pattern_pins_o[7:0] ^ $past(pattern_pins_o[7:0])) & $past(pattern_active_o[7:0])) == 8'h00;
  endproperty
  a_ro: assert property (p_ro) else $error("enabled pin took a software write");
  property p_act;
    (pattern_active_o & ~pattern_pins_oe_o) == 16'h0000;
  endproperty
  a_act: assert property (p_act) else $error("pattern pin active without direction");
  property p_rst;
    $fell(rst_i) |-> pattern_active_o == 16'h0000 && pattern_pins_o == 16'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("enables not clear after reset");
  property p_stby;
    disable iff (rst_i) hw_standby_i [*6] |-> pattern_active_o == 16'h0000;
  endproperty
  a_stby: assert property (p_stby) else $error("enables not clear in standby");
  property p_err;
    pslverr |-> psel && penable;
  endproperty
  a_err: assert property (p_err) else $error("error flag outside access phase");
endmodule

bind pot_top pot_top_monitor #(.ADDR_W(ADDR_W)) i_mon (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .hw_standby_i(hw_standby_i), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pslverr(pslverr), .cmp_match_i(cmp_match_i), .pattern_pins_o(pattern_pins_o),
  .pattern_pins_oe_o(pattern_pins_oe_o), .pattern_active_o(pattern_active_o));

// file: testbench/pot_timer_model.sv
// Timer channel model giving delayed one-cycle compare match strobes
`timescale 1ns/1ps
module pot_timer_model (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // Command
  input  wire logic       arm_i,
  input  wire logic [1:0] ch_i,
  input  wire logic [3:0] dly_i,
  // Strobes
  output logic      [2:0] cmp_match_o
);
  logic [2:0] cm_q;
  logic [3:0] cnt_q;
  logic [1:0] ch_q;
  logic       run_q;
  assign cmp_match_o = cm_q;
  // Strobes last one cycle, as a real compare match does
  always_ff @(posedge core_clk_i) begin
    cm_q <= 3'h0;
    if (rst_i) begin
      run_q <= 1'b0;
    end else if (arm_i) begin
      run_q <= 1'b1;
      cnt_q <= dly_i;
      ch_q  <= ch_i;
    end else if (run_q && cnt_q == 4'h0) begin
      run_q      <= 1'b0;
      cm_q[ch_q] <= 1'b1;
    end else if (run_q) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule

// file: testbench/tb_pattern_output_enable_trigger.sv
// Testbench of the pattern output unit
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module tb_pattern_output_enable_trigger;
  import pot_pkg::*;
  logic        core_clk_i   = 1'b0;
  logic        rst_i        = 1'b1;
  logic        hw_standby_i = 1'b0;
  logic        psel         = 1'b0;
  logic        penable      = 1'b0;
  logic        pwrite       = 1'b0;
  logic [7:0]  paddr        = 8'h00;
  logic [31:0] pwdata       = 32'h0000_0000;
  logic [3:0]  pstrb        = 4'hF;
  logic        arm          = 1'b0;
  logic [1:0]  arm_ch       = 2'h0;
  logic [3:0]  arm_dly      = 4'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err;
  logic [2:0]  cmp_match;
  logic [15:0] pins, oe, act, pins_exp;
  int          fail_count   = 0;
  int          comparisons  = 0;
  int          cycles       = 0;
  always #25 core_clk_i = ~core_clk_i;
  pot_top i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .hw_standby_i(hw_standby_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmp_match_i(cmp_match), .pattern_pins_o(pins),
    .pattern_pins_oe_o(oe), .pattern_active_o(act));
  pot_timer_model i_tmr (.core_clk_i(core_clk_i), .rst_i(rst_i), .arm_i(arm), .ch_i(arm_ch),
    .dly_i(arm_dly), .cmp_match_o(cmp_match));
  // ******************************
  // Bus and strobe tasks
  // ******************************
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk_i);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    do @(posedge core_clk_i); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'b1, {24'h0000_00, d});
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0000_0000);
    `CHK(rd, e)
  endtask
  // Slow and prompt strobes both reach the design
  task automatic fire(input logic [1:0] ch, input logic [3:0] dly);
    @(posedge core_clk_i);
    arm     <= 1'b1;
    arm_ch  <= ch;
    arm_dly <= dly;
    @(posedge core_clk_i);
    arm     <= 1'b0;
    do @(posedge core_clk_i); while (cmp_match[ch] !== 1'b1);
    @(negedge core_clk_i);
  endtask
  // ******************************
  // Scenarios
  // ******************************
  task automatic t_reset();
    rdchk(POT_OFS_LOW_EN, 32'h0000_0000);
    rdchk(POT_OFS_HIGH_EN, 32'h0000_0000);
    rdchk(POT_OFS_TRIG_SEL, 32'h0000_00FF);
    apb(8'h28, 1'b1, 32'h0000_0011);
    `CHK(err, 1'b1)
    rdchk(8'h28, 32'h0000_0000);
  endtask
  task automatic t_rw();
    wr(POT_OFS_LOW_EN, 8'hA5);
    rdchk(POT_OFS_LOW_EN, 32'h0000_00A5);
    wr(POT_OFS_HIGH_EN, 8'h5A);
    rdchk(POT_OFS_HIGH_EN, 32'h0000_005A);
    pstrb <= 4'h0;
    wr(POT_OFS_TRIG_SEL, 8'h12);
    pstrb <= 4'hF;
    rdchk(POT_OFS_TRIG_SEL, 32'h0000_00FF);
  endtask
  task automatic t_transfer();
    logic [7:0]  sel [5] = '{8'h00, 8'h55, 8'hAA, 8'hFF, 8'h93};
    logic [15:0] stg;
    logic [15:0] m;
    int          sc;
    wr(POT_OFS_LOW_EN, 8'h00);
    wr(POT_OFS_HIGH_EN, 8'h00);
    wr(POT_OFS_PORT_A, 8'h00);
    wr(POT_OFS_PORT_B, 8'h00);
    wr(POT_OFS_LOW_EN, 8'h3C);
    wr(POT_OFS_HIGH_EN, 8'hC3);
    pins_exp = 16'h0000;
    foreach (sel[i]) begin
      wr(POT_OFS_TRIG_SEL, sel[i]);
      for (int ch = 0; ch < 3; ch++) begin
        // Staging the inverse makes every enabled selected pin move
        stg = ~pins_exp;
        wr(POT_OFS_LOW_STG, stg[7:0]);
        wr(POT_OFS_HIGH_STG, stg[15:8]);
        fire(2'(ch), 4'(ch * 3));
        for (int g = 0; g < 4; g++) begin
          sc = sel[i][2*g+1] ? 2 : int'(sel[i][2*g]);
          m  = (sc == ch) ? (16'hC33C & (16'h000F << (4 * g))) : 16'h0000;
          pins_exp = (pins_exp & ~m) | (stg & m);
        end
        `CHK(pins, pins_exp)
      end
    end
  endtask
  task automatic t_ro();
    wr(POT_OFS_DIR_A, 8'hFF);
    wr(POT_OFS_DIR_B, 8'h0F);
    // Outputs of the access edge settle by the falling edge
    @(negedge core_clk_i);
    `CHK(oe, 16'h0FFF)
    `CHK(act, 16'h033C)
    rdchk(POT_OFS_STATUS, 32'h0000_033C);
    wr(POT_OFS_PORT_A, 8'hFF);
    wr(POT_OFS_PORT_B, 8'h00);
    @(negedge core_clk_i);
    pins_exp = (pins_exp & 16'hC33C) | 16'h00C3;
    `CHK(pins, pins_exp)
  endtask
  task automatic t_standby();
    hw_standby_i <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    hw_standby_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    `CHK(act, 16'h0000)
    rdchk(POT_OFS_LOW_EN, 32'h0000_0000);
    rdchk(POT_OFS_HIGH_EN, 32'h0000_0000);
    rdchk(POT_OFS_TRIG_SEL, 32'h0000_00FF);
    wr(POT_OFS_HIGH_EN, 8'h81);
    rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rdchk(POT_OFS_HIGH_EN, 32'h0000_0000);
  endtask
  // ******************************
  // Verdict and run control
  // ******************************
  task automatic test_done();
    if (fail_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Whole run needs under 2000 cycles
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_rw();
    t_transfer();
    t_ro();
    t_standby();
    test_done();
  end
endmodule
